// ---- src/sce_consts.vh ----
`ifndef SCE_CONSTS_VH
`define SCE_CONSTS_VH
// =====================================================================
// Register map.
`define SCE_ADDR_W 8
`define SCE_OFF_CTRL1 8'h42
`define SCE_OFF_CTRL2 8'h43
`define SCE_OFF_STAT 8'h44
`define SCE_OFF_DATA 8'h47
`define SCE_OFF_BAUD 8'h41
`define SCE_CTRL2_RST 8'h00
`define SCE_CTRL1_RST 8'h00
`define SCE_BAUD_RST 8'h04
// =====================================================================
// Control register 2 fields.
`define SCE_B_TXE_IE 7
`define SCE_B_TXD_IE 6
`define SCE_B_RXF_IE 5
`define SCE_B_IDLE_IE 4
`define SCE_B_TX_ON 3
`define SCE_B_RX_ON 2
`define SCE_B_STBY 1
`define SCE_B_BRK 0
// =====================================================================
// Control register 1 fields.
`define SCE_B_LOOP 7
`define SCE_B_DIR 6
`define SCE_B_SRC 5
`define SCE_B_NINE 4
`define SCE_B_WAKE 3
`define SCE_B_LBRK 2
// =====================================================================
// Timing: oversampling per bit, break lengths in bit times.
`define SCE_OVS 16
`define SCE_BRK_SHORT 4'd10
`define SCE_BRK_SHORT9 4'd11
`define SCE_BRK_LONG 4'd13
`define SCE_BRK_LONG9 4'd14
`endif

// ---- src/sce_sync.v ----
`timescale 1ns/1ps
// =====================================================================
// Two flip-flop synchroniser for a pin input.
module sce_sync (
  input wire mclk_i,
  input wire rst_i,
  input wire d_i,
  output reg q_o
);
  reg meta_r;
  // The first stage feeds only the second.
  always @(posedge mclk_i) begin
    if (rst_i) begin
      meta_r <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // sce_sync

// ---- src/sce_baud.v ----
`timescale 1ns/1ps
`include "sce_consts.vh"
// =====================================================================
// Baud tick generator: one pulse every divisor cycles, 16 per bit.
module sce_baud (
  input wire mclk_i,
  input wire rst_i,
  input wire [12:0] div_i,
  output reg tick_o
);
  reg [12:0] cnt_r;
  // A zero divisor stops the generator.
  always @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_r <= 13'h0000;
      tick_o <= 1'b0;
    end else if (div_i == 13'h0000) begin
      cnt_r <= 13'h0000;
      tick_o <= 1'b0;
    end else if (cnt_r >= div_i - 13'h0001) begin
      cnt_r <= 13'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 13'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule // sce_baud

// ---- src/sce_ctrl.v ----
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "sce_consts.vh"
module sce_ctrl (
  input wire mclk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire rxd_pin_i,
  input wire txd_pin_i,
  output reg txd_o,
  output reg txd_oe_o,
  output reg rxd_own_o,
  output reg irq_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SHIFT = 2'd1;
  localparam ST_BREAK = 2'd2;
  localparam ST_PRE = 2'd3;
  localparam RS_IDLE = 2'd0;
  localparam RS_DATA = 2'd1;
  localparam RS_STOP = 2'd2;

  reg [7:0] ctrl2_r;
  reg [7:0] ctrl1_r;
  reg [12:0] baud_r;
  reg [8:0] txbuf_r;
  reg tx_buffer_empty_flag_r;
  reg tc_r;
  reg rx_buffer_full_flag_r;
  reg idle_r;
  reg [8:0] rxbuf_r;
  reg [1:0] tst_r;
  reg [10:0] tsh_r;
  reg [3:0] tbits_r;
  reg [3:0] tovs_r;
  reg idle_q_r;
  reg brk_q_r;
  reg tx_on_d_r;
  reg tx_line_r;
  reg [1:0] rst_st_r;
  reg [3:0] rovs_r;
  reg [3:0] rbits_r;
  reg [8:0] rsh_r;
  reg [3:0] idle_cnt_r;
  reg idle_armed_r;
  reg stat_seen_r;
  wire tick;
  wire rxd_s;
  wire txd_s;
  wire loop_w;
  wire single_w;
  wire nine_w;
  wire rx_in;
  wire rx_active;
  wire tx_busy;
  wire bit_end;
  wire rbit_mid;
  wire rbit_end;

  sce_baud u_baud (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .div_i(baud_r),
    .tick_o(tick)
  );
  sce_sync u_sync_rx (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(rxd_pin_i),
    .q_o(rxd_s)
  );
  sce_sync u_sync_tx (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(txd_pin_i),
    .q_o(txd_s)
  );

  // Frame length in bits, start and stop included.
  function [3:0] frame_bits;
    input nine;
    begin
      frame_bits = nine ? 4'd11 : 4'd10;
    end
  endfunction

  // Break length follows character format and long-break select.
  function [3:0] brk_bits;
    input nine;
    input lng;
    begin
      if (lng) begin
        brk_bits = nine ? `SCE_BRK_LONG9 : `SCE_BRK_LONG;
      end else begin
        brk_bits = nine ? `SCE_BRK_SHORT9 : `SCE_BRK_SHORT;
      end
    end
  endfunction

  assign loop_w = ctrl1_r[`SCE_B_LOOP];
  assign single_w = loop_w & ctrl1_r[`SCE_B_SRC];
  assign nine_w = ctrl1_r[`SCE_B_NINE];
  assign tx_busy = (tst_r != ST_IDLE);
  assign bit_end = tick & (tovs_r == 4'hf);
  // Receiver input: pin, internal loop or single-wire line.
  assign rx_in = !loop_w ? rxd_s : (single_w ? (ctrl1_r[`SCE_B_DIR] ? tx_line_r : txd_s) : tx_line_r);
  assign rx_active = ctrl2_r[`SCE_B_RX_ON];
  assign rbit_mid = tick & (rovs_r == 4'h7);
  assign rbit_end = tick & (rovs_r == 4'hf);

  // =====================================================================
  // Register writes, status-read tracking and hardware clearing of standby.
  always @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl2_r <= `SCE_CTRL2_RST;
      ctrl1_r <= `SCE_CTRL1_RST;
      baud_r <= {5'h00, `SCE_BAUD_RST};
      txbuf_r <= 9'h000;
      stat_seen_r <= 1'b0;
    end else begin
      if (rd_i && addr_i == `SCE_OFF_STAT) begin
        stat_seen_r <= 1'b1;
      end else if (rd_i || wr_i) begin
        stat_seen_r <= 1'b0;
      end
      if (wr_i) begin
        case (addr_i)
          `SCE_OFF_CTRL2: ctrl2_r <= wdata_i;
          `SCE_OFF_CTRL1: ctrl1_r <= wdata_i;
          `SCE_OFF_BAUD: baud_r <= {5'h00, wdata_i};
          `SCE_OFF_DATA: txbuf_r <= {ctrl1_r[0], wdata_i};
          default: ;
        endcase
      end else if (ctrl2_r[`SCE_B_STBY] && rst_st_r == RS_STOP && rbit_mid) begin
        // Hardware wake-up clears standby; address mark or idle line.
        if (ctrl1_r[`SCE_B_WAKE] ? (nine_w ? rsh_r[8] : rsh_r[7]) : 1'b0) begin
          ctrl2_r[`SCE_B_STBY] <= 1'b0;
        end
      end else if (ctrl2_r[`SCE_B_STBY] && !ctrl1_r[`SCE_B_WAKE] && rx_in && idle_cnt_r == frame_bits(nine_w)) begin
        ctrl2_r[`SCE_B_STBY] <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Transmitter: data, queued idle and queued break share one bit counter; only data uses the shifter.
  always @(posedge mclk_i) begin
    if (rst_i) begin
      tst_r <= ST_IDLE;
      tsh_r <= 11'h7ff;
      tbits_r <= 4'h0;
      tovs_r <= 4'h0;
      tx_buffer_empty_flag_r <= 1'b1;
      tc_r <= 1'b1;
      idle_q_r <= 1'b0;
      brk_q_r <= 1'b0;
      tx_on_d_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else begin
      tx_on_d_r <= ctrl2_r[`SCE_B_TX_ON];
      if (wr_i && addr_i == `SCE_OFF_DATA && stat_seen_r) begin
        tx_buffer_empty_flag_r <= 1'b0;
        tc_r <= 1'b0;
      end
      // Off-then-on while busy queues one idle character.
      if (ctrl2_r[`SCE_B_TX_ON] && !tx_on_d_r && tx_busy) begin
        idle_q_r <= 1'b1;
      end
      // Falling edge of the break bit queues a break.
      if (wr_i && addr_i == `SCE_OFF_CTRL2 && ctrl2_r[`SCE_B_BRK] && !wdata_i[`SCE_B_BRK]) begin
        brk_q_r <= 1'b1;
      end
      if (tick) begin
        tovs_r <= tovs_r + 4'h1;
      end
      case (tst_r)
        ST_IDLE: begin
          tovs_r <= 4'h0;
          tx_line_r <= 1'b1;
          if (brk_q_r || (ctrl2_r[`SCE_B_BRK] && ctrl2_r[`SCE_B_TX_ON])) begin
            tst_r <= ST_BREAK;
            brk_q_r <= 1'b0;
            tbits_r <= brk_bits(nine_w, ctrl1_r[`SCE_B_LBRK]);
            tc_r <= 1'b0;
          end else if (idle_q_r) begin
            tst_r <= ST_PRE;
            idle_q_r <= 1'b0;
            tbits_r <= frame_bits(nine_w);
          end else if (ctrl2_r[`SCE_B_TX_ON] && !tx_buffer_empty_flag_r) begin
            tst_r <= ST_SHIFT;
            tx_buffer_empty_flag_r <= 1'b1;
            tbits_r <= frame_bits(nine_w);
            tsh_r <= nine_w ? {1'b1, txbuf_r, 1'b0} : {2'b11, txbuf_r[7:0], 1'b0};
          end else if (tx_buffer_empty_flag_r) begin
            tc_r <= 1'b1;
          end
        end
        ST_SHIFT: begin
          tx_line_r <= tsh_r[0];
          if (bit_end) begin
            tsh_r <= {1'b1, tsh_r[10:1]};
            tbits_r <= tbits_r - 4'h1;
            if (tbits_r == 4'h1) begin
              tst_r <= ST_IDLE;
            end
          end
        end
        default: begin
          // Break sends zeros, queued idle sends ones.
          tx_line_r <= (tst_r == ST_PRE);
          if (bit_end) begin
            tbits_r <= tbits_r - 4'h1;
            if (tbits_r == 4'h1) begin
              tst_r <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // =====================================================================
  // Receiver with standby and idle-line detection.
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rst_st_r <= RS_IDLE;
      rovs_r <= 4'h0;
      rbits_r <= 4'h0;
      rsh_r <= 9'h000;
      rxbuf_r <= 9'h000;
      rx_buffer_full_flag_r <= 1'b0;
      idle_r <= 1'b0;
      idle_cnt_r <= 4'h0;
      idle_armed_r <= 1'b0;
    end else begin
      if (rd_i && addr_i == `SCE_OFF_DATA && stat_seen_r) begin
        rx_buffer_full_flag_r <= 1'b0;
        idle_r <= 1'b0;
      end
      if (!rx_active) begin
        rst_st_r <= RS_IDLE;
        rovs_r <= 4'h0;
      end else begin
        if (tick) begin
          rovs_r <= rovs_r + 4'h1;
        end
        // Idle counter runs in whole bit times of high line.
        if (rbit_end) begin
          if (!rx_in || rst_st_r != RS_IDLE) begin
            idle_cnt_r <= 4'h0;
          end else if (idle_cnt_r != 4'hf) begin
            idle_cnt_r <= idle_cnt_r + 4'h1;
          end
        end
        if (idle_armed_r && idle_cnt_r == frame_bits(nine_w) && !ctrl2_r[`SCE_B_STBY]) begin
          idle_r <= 1'b1;
          idle_armed_r <= 1'b0;
        end
        case (rst_st_r)
          RS_IDLE: begin
            if (!rx_in) begin
              rst_st_r <= RS_DATA;
              rovs_r <= 4'h0;
              rbits_r <= nine_w ? 4'd9 : 4'd8;
            end
          end
          RS_DATA: begin
            // The first mid-bit sample falls in the start bit and is skipped.
            if (rbit_mid && rbits_r != (nine_w ? 4'd9 : 4'd8)) begin
              rsh_r <= nine_w ? {rx_in, rsh_r[8:1]} : {1'b0, rx_in, rsh_r[7:1]};
            end
            if (rbit_end) begin
              rbits_r <= rbits_r - 4'h1;
              if (rbits_r == 4'h0) begin
                rst_st_r <= RS_STOP;
              end
            end
          end
          RS_STOP: begin
            if (rbit_mid) begin
              rst_st_r <= RS_IDLE;
              // Standby suppresses delivery to the buffer.
              if (!ctrl2_r[`SCE_B_STBY]) begin
                rxbuf_r <= rsh_r;
                rx_buffer_full_flag_r <= 1'b1;
                idle_armed_r <= 1'b1;
              end
            end
          end
          default: rst_st_r <= RS_IDLE;
        endcase
      end
    end
  end

  // =====================================================================
  // Outputs: pin ownership, line level, interrupt and read data.
  always @(posedge mclk_i) begin
    if (rst_i) begin
      txd_o <= 1'b1;
      txd_oe_o <= 1'b0;
      rxd_own_o <= 1'b0;
      irq_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      txd_o <= tx_line_r;
      if (single_w) begin
        txd_oe_o <= ctrl1_r[`SCE_B_DIR] & (ctrl2_r[`SCE_B_TX_ON] | tx_busy);
      end else begin
        txd_oe_o <= ctrl2_r[`SCE_B_TX_ON] | tx_busy | idle_q_r | brk_q_r;
      end
      rxd_own_o <= rx_active & !loop_w;
      irq_o <= (ctrl2_r[`SCE_B_TXE_IE] & tx_buffer_empty_flag_r) |
               (ctrl2_r[`SCE_B_TXD_IE] & tc_r) |
               (ctrl2_r[`SCE_B_RXF_IE] & rx_buffer_full_flag_r) |
               (ctrl2_r[`SCE_B_IDLE_IE] & idle_r);
      rdata_o <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          `SCE_OFF_CTRL2: rdata_o <= ctrl2_r;
          `SCE_OFF_CTRL1: rdata_o <= ctrl1_r;
          `SCE_OFF_BAUD: rdata_o <= baud_r[7:0];
          `SCE_OFF_STAT: rdata_o <= {tx_buffer_empty_flag_r, tc_r, rx_buffer_full_flag_r, idle_r, 4'h0};
          `SCE_OFF_DATA: rdata_o <= rxbuf_r[7:0];
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule // sce_ctrl

// ---- sim/sce_ctrl_props.sv ----
`timescale 1ns/1ps
`include "sce_consts.vh"
// =====================================================================
// Port checker for the control-enable block.
module sce_ctrl_props (
  input wire mclk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire rxd_pin_i,
  input wire txd_pin_i,
  input wire txd_o,
  input wire txd_oe_o,
  input wire rxd_own_o,
  input wire irq_o
);
  reg [7:0] c1_r;
  reg [7:0] c2_r;
  default clocking cb @(posedge mclk_i); endclocking
  // Shadows of both control registers as software wrote them.
  always @(posedge mclk_i) begin
    if (rst_i) begin
      c1_r <= 8'h00;
      c2_r <= 8'h00;
    end else if (wr_i && addr_i == `SCE_OFF_CTRL1) begin
      c1_r <= wdata_i;
    end else if (wr_i && addr_i == `SCE_OFF_CTRL2) begin
      c2_r <= wdata_i;
    end
  end
  AST_RST: assert property (rst_i |=> !txd_oe_o && !rxd_own_o && !irq_o && txd_o && rdata_o == 8'h00)
    else $error("Outputs not idle after reset.");
  AST_RD_IDLE: assert property (disable iff (rst_i) !rd_i |=> rdata_o == 8'h00)
    else $error("Read data outside read cycle.");
  AST_RD_BACK: assert property (disable iff (rst_i) rd_i && addr_i == `SCE_OFF_CTRL2 |=>
    (rdata_o & 8'hfd) == (c2_r & 8'hfd)) else $error("Control read back differs.");
  AST_TX_WR: assert property (disable iff (rst_i) wr_i && addr_i == `SCE_OFF_CTRL2 && wdata_i[3] && !c1_r[7]
    |-> ##2 txd_oe_o) else $error("Transmit pin not taken.");
  AST_TX_OWN: assert property (disable iff (rst_i) c2_r[3] && !c1_r[7] |=> txd_oe_o)
    else $error("Transmit pin released while on.");
  AST_SW_DIR: assert property (disable iff (rst_i) c1_r[7] && c1_r[5] && !c1_r[6] |=> !txd_oe_o)
    else $error("Single-wire receive still drives.");
  AST_RX_OWN: assert property (disable iff (rst_i) c2_r[2] && !c1_r[7] |=> rxd_own_o)
    else $error("Receive pin not owned.");
  AST_RX_LOOP: assert property (disable iff (rst_i) !c2_r[2] || c1_r[7] |=> !rxd_own_o)
    else $error("Receive pin not released.");
  AST_IRQ_OFF: assert property (disable iff (rst_i) c2_r[7:4] == 4'h0 |=> !irq_o)
    else $error("Interrupt with all enables off.");
  COV_IRQ: cover property ($rose(irq_o));
  COV_BRK: cover property ((txd_oe_o && !txd_o) [*8]);
  COV_LOOP: cover property ($fell(rxd_own_o));
endmodule // sce_ctrl_props
bind sce_ctrl sce_ctrl_props i_sce_ctrl_props (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_pin_i(rxd_pin_i),
  .txd_pin_i(txd_pin_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .rxd_own_o(rxd_own_o), .irq_o(irq_o));

// ---- sim/sce_remote_node.sv ----
`timescale 1ns/1ps
// =====================================================================
// Remote node: drives the receive line, times low spans on the line.
module sce_remote_node #(
  parameter BIT_CYC = 64
) (
  input wire mclk_i,
  input wire txd_i,
  output reg rxd_o,
  output reg [15:0] low_len_o,
  output reg [7:0] n_low_o
);
  reg [15:0] cnt_r;
  initial begin
    rxd_o = 1'b1;
    cnt_r = 16'h0000;
    low_len_o = 16'h0000;
    n_low_o = 8'h00;
  end
  // Each finished low span is stored with its length in cycles.
  always @(posedge mclk_i) begin
    if (txd_i === 1'b0) begin
      cnt_r <= cnt_r + 16'h0001;
    end else if (cnt_r != 16'h0000) begin
      low_len_o <= cnt_r;
      n_low_o <= n_low_o + 8'h01;
      cnt_r <= 16'h0000;
    end
  end
  // One frame: start, eight data bits LSB first, stop; idle stays high.
  task send(input [7:0] b);
    integer i;
    begin
      for (i = 0; i < 10; i = i + 1) begin
        @(posedge mclk_i);
        rxd_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
        repeat (BIT_CYC - 1) @(posedge mclk_i);
      end
    end
  endtask
endmodule // sce_remote_node

// ---- sim/sce_ctrl_test.sv ----
`timescale 1ns/1ps
`include "sce_consts.vh"
`define CHK(a, b) begin comparisons = comparisons + 1; if ((a) !== (b)) begin n_fail = n_fail + 1; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, a, b); end end
// =====================================================================
// Self-checking bench for the control-enable block.
module sce_ctrl_test;
  localparam integer BIT = `SCE_OVS * `SCE_BAUD_RST;
  reg mclk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [7:0] addr_i = 8'h00;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  wire [7:0] rdata_o;
  wire rxd;
  wire txd_o;
  wire txd_oe_o;
  wire rxd_own_o;
  wire irq_o;
  wire pin;
  wire [15:0] low_len;
  wire [7:0] n_low;
  integer n_fail = 0;
  integer comparisons = 0;
  integer k;
  reg [7:0] n0;
  // The line has a pull-up, so a released pin reads high.
  assign pin = txd_oe_o ? txd_o : 1'b1;
  always #20 mclk_i = ~mclk_i;
  sce_ctrl i_sce_ctrl (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .rxd_pin_i(rxd), .txd_pin_i(pin), .txd_o(txd_o), .txd_oe_o(txd_oe_o),
    .rxd_own_o(rxd_own_o), .irq_o(irq_o));
  sce_remote_node #(.BIT_CYC(BIT)) i_sce_remote_node (.mclk_i(mclk_i), .txd_i(pin), .rxd_o(rxd),
    .low_len_o(low_len), .n_low_o(n_low));
  // Bus write and read cycles.
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 `CHK(rdata_o, e)
    end
  endtask
  task settle(input integer n);
    begin
      repeat (n) @(posedge mclk_i);
      #1;
    end
  endtask
  // Waits for the next low span and checks its length in bit times.
  task brk(input integer bits);
    begin
      k = 0;
      while (n_low == n0 && k < 4000) begin
        @(posedge mclk_i);
        k = k + 1;
      end
      `CHK(low_len >= bits * BIT - 4 && low_len <= (bits + 1) * BIT + 4, 1'b1)
    end
  endtask
  task report_and_stop;
    begin
      $display("mismatches=%0d comparisons=%0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    #(40 * 40000);
    n_fail = n_fail + 1;
    report_and_stop;
  end
  // Main sequence.
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(`SCE_OFF_CTRL2, 8'h00);
    rd(8'h50, 8'h00);
    for (k = 0; k < 4; k = k + 1) begin
      wr(`SCE_OFF_CTRL2, 8'h80 >> k);
      settle(2);
      `CHK(irq_o, k < 2)
      rd(`SCE_OFF_CTRL2, 8'h80 >> k);
    end
    wr(`SCE_OFF_CTRL2, 8'h0c);
    settle(3);
    `CHK({txd_oe_o, rxd_own_o, irq_o}, 3'b110)
    wr(`SCE_OFF_CTRL1, 8'h80);
    settle(3);
    `CHK(rxd_own_o, 1'b0)
    wr(`SCE_OFF_CTRL1, 8'ha0);
    settle(3);
    `CHK(txd_oe_o, 1'b0)
    wr(`SCE_OFF_CTRL1, 8'he0);
    settle(3);
    `CHK(txd_oe_o, 1'b1)
    wr(`SCE_OFF_CTRL1, 8'h00);
    wr(`SCE_OFF_CTRL2, 8'h00);
    settle(12 * BIT);
    `CHK({txd_oe_o, rxd_own_o}, 2'b00)
    n0 = n_low;
    wr(`SCE_OFF_CTRL2, 8'h09);
    wr(`SCE_OFF_CTRL2, 8'h08);
    wr(`SCE_OFF_CTRL2, 8'h00);
    settle(20);
    `CHK(txd_oe_o, 1'b1)
    brk(`SCE_BRK_SHORT);
    n0 = n_low;
    brk(`SCE_BRK_SHORT);
    settle(3 * BIT);
    `CHK(txd_oe_o, 1'b0)
    n0 = n_low;
    wr(`SCE_OFF_CTRL1, 8'h04);
    wr(`SCE_OFF_CTRL2, 8'h09);
    wr(`SCE_OFF_CTRL2, 8'h08);
    brk(`SCE_BRK_LONG);
    wr(`SCE_OFF_CTRL2, 8'h04);
    wr(`SCE_OFF_CTRL1, 8'h08);
    wr(`SCE_OFF_CTRL2, 8'h06);
    i_sce_remote_node.send(8'h01);
    settle(2 * BIT);
    rd(`SCE_OFF_CTRL2, 8'h06);
    i_sce_remote_node.send(8'h81);
    settle(2 * BIT);
    rd(`SCE_OFF_CTRL2, 8'h04);
    wr(`SCE_OFF_CTRL1, 8'h00);
    wr(`SCE_OFF_CTRL2, 8'h06);
    settle(13 * BIT);
    rd(`SCE_OFF_CTRL2, 8'h04);
    report_and_stop;
  end
endmodule // sce_ctrl_test
